/* File: verilog/fuel_gauge_pkg.sv */
package fuel_gauge_pkg;

  // ==========================================================================
  // Link addressing and command codes
  // ==========================================================================
  localparam logic [6:0]  SLAVE_ADDRESS               = 7'h47;
  localparam logic [7:0]  STATUS_READ_COMMAND         = 8'h01;
  localparam logic [7:0]  CONFIGURATION_WRITE_COMMAND = 8'h02;
  localparam logic [3:0]  BITS_PER_BYTE               = 4'h8;
  localparam logic [7:0]  UNKNOWN_READ_BYTE           = 8'hFF;

  // ==========================================================================
  // Status word layout
  // ==========================================================================
  localparam logic [15:0] STATUS_ONES     = 16'hFF01;
  localparam int          ST_DISCHARGE_OC = 7;
  localparam int          ST_CHARGE_OC    = 6;
  localparam int          ST_COMPARE      = 5;
  localparam int          ST_COUNTER_SEL  = 4;
  localparam int          ST_SHUTDOWN     = 3;
  localparam int          ST_DIRECTION    = 2;
  localparam int          ST_DIR_CHANGE   = 1;

  // ==========================================================================
  // Configuration word layout
  // ==========================================================================
  localparam int          CFG_SOFT_SHUTDOWN    = 9;
  localparam int          CFG_CLEAR_INTERRUPTS = 7;
  localparam int          CFG_COUNTER_SELECT   = 6;
  localparam logic [15:0] CFG_STORE_MASK       = 16'h067F;
  localparam logic [15:0] CFG_RESET            = 16'h0000;

  // ==========================================================================
  // Link states
  // ==========================================================================
  typedef enum logic [3:0] {
    LINK_IDLE      = 4'h0,
    LINK_ADDR      = 4'h1,
    LINK_ADDR_ACK  = 4'h2,
    LINK_CMD       = 4'h3,
    LINK_CMD_ACK   = 4'h4,
    LINK_WDATA     = 4'h5,
    LINK_WDATA_ACK = 4'h6,
    LINK_TX        = 4'h7,
    LINK_TX_ACK    = 4'h8,
    LINK_IGNORE    = 4'h9
  } link_state_e;

endpackage : fuel_gauge_pkg

/* File: verilog/smbus_line_sampler.sv */
`timescale 1ns/100ps
module smbus_line_sampler (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Bus lines
  input  wire logic scl,
  input  wire logic sda_in,
  // Decoded line events
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_seen,
  output logic      stop_seen,
  output logic      sda_level
);

  // ==========================================================================
  // State: bit 0 is the clock line, bit 1 the data line
  // ==========================================================================
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;
  } sampler_s;

  sampler_s q;
  sampler_s next_q;

  always_comb begin
    next_q      = q;
    next_q.meta = {sda_in, scl};
    next_q.sync = q.meta;
    next_q.prev = q.sync;
  end

  // Lines idle high, so reset to high to avoid false edges
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{meta: 2'h3, sync: 2'h3, prev: 2'h3};
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================================
  // Edge and condition decode
  // ==========================================================================
  assign scl_rise   = q.sync[0] & ~q.prev[0];
  assign scl_fall   = ~q.sync[0] & q.prev[0];
  assign start_seen = q.sync[0] & q.prev[0] & q.prev[1] & ~q.sync[1];
  assign stop_seen  = q.sync[0] & q.prev[0] & ~q.prev[1] & q.sync[1];
  assign sda_level  = q.sync[1];

endmodule : smbus_line_sampler

/* File: verilog/fuel_gauge_status_word.sv */
`timescale 1ns/100ps
// Contract
// - Read-Word of status command returns status word
// - Receive-Byte returns status low byte when status command latched, else FF
// - Command code latched until next command
// - Bits 15..8 and bit 0 read one
// - Bit 7 sets on discharge overcurrent
// - Bit 6 sets on charge overcurrent
// - Overcurrent flags clear: shutdown, reset, clear write
// - Bit 5 compare flag, same clears
// - Bit 4 mirrors counter select
// - Bit 3 shows soft shutdown
// - Bit 2 follows detected current direction
// - Bit 1 sets on direction reversal
// - Config bit 7 write clears four flags
// - Config bit 9 enables soft shutdown
// - Config bit 6 selects charge counter
// - Only fixed slave address, never master
module fuel_gauge_status_word (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Bus pins
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  // Events from the measurement logic
  input  wire logic        discharge_overcurrent_event,
  input  wire logic        charge_overcurrent_event,
  input  wire logic        compare_interrupt,
  input  wire logic        charge_current_detected,
  input  wire logic        discharge_current_detected,
  // Configuration outputs
  output logic [15:0]      configuration_word,
  output logic             soft_shutdown_enable,
  output logic             counter_select,
  output logic             clear_interrupts,
  // Status view
  output logic [15:0]      device_status_word
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    fuel_gauge_pkg::link_state_e st;
    logic [7:0]                  shreg;
    logic [3:0]                  bitcnt;
    logic                        rw;
    logic                        byte_idx;
    logic [7:0]                  cmd_latch;
    logic [7:0]                  wlow;
    logic [15:0]                 config_word;
    logic                        sda_drive;
    logic                        clear_interrupts;
    logic                        discharge_overcurrent_flag;
    logic                        charge_overcurrent_flag;
    logic                        compare_match_flag;
    logic                        current_direction_indicator;
    logic                        direction_change_flag;
  } gauge_s;

  gauge_s q;
  gauge_s next_q;

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic sda_level;
  logic rx_state;
  logic rx_done;
  logic shutdown;
  logic flag_clear;
  logic dir_reverse;
  logic [15:0] status_now;

  smbus_line_sampler u_sampler (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .scl        (scl),
    .sda_in     (sda_in),
    .scl_rise   (scl_rise),
    .scl_fall   (scl_fall),
    .start_seen (start_seen),
    .stop_seen  (stop_seen),
    .sda_level  (sda_level)
  );

  // ==========================================================================
  // Byte sent for the latched command
  // ==========================================================================
  function automatic logic [7:0] read_byte(input logic [7:0]  cmd,
                                           input logic        high,
                                           input logic [15:0] status);
    if (cmd == fuel_gauge_pkg::STATUS_READ_COMMAND) begin
      read_byte = high ? status[15:8] : status[7:0];
    end else begin
      read_byte = fuel_gauge_pkg::UNKNOWN_READ_BYTE;
    end
  endfunction : read_byte

  // ==========================================================================
  // Status word assembly
  // ==========================================================================
  always_comb begin
    status_now = fuel_gauge_pkg::STATUS_ONES;
    status_now[fuel_gauge_pkg::ST_DISCHARGE_OC] = q.discharge_overcurrent_flag;
    status_now[fuel_gauge_pkg::ST_CHARGE_OC]    = q.charge_overcurrent_flag;
    status_now[fuel_gauge_pkg::ST_COMPARE]      = q.compare_match_flag;
    status_now[fuel_gauge_pkg::ST_COUNTER_SEL]  =
      q.config_word[fuel_gauge_pkg::CFG_COUNTER_SELECT];
    status_now[fuel_gauge_pkg::ST_SHUTDOWN]     =
      q.config_word[fuel_gauge_pkg::CFG_SOFT_SHUTDOWN];
    status_now[fuel_gauge_pkg::ST_DIRECTION]    = q.current_direction_indicator;
    status_now[fuel_gauge_pkg::ST_DIR_CHANGE]   = q.direction_change_flag;
  end

  assign rx_state = (q.st == fuel_gauge_pkg::LINK_ADDR) ||
                    (q.st == fuel_gauge_pkg::LINK_CMD) ||
                    (q.st == fuel_gauge_pkg::LINK_WDATA);
  assign rx_done    = rx_state && scl_fall && (q.bitcnt == fuel_gauge_pkg::BITS_PER_BYTE);
  assign shutdown   = q.config_word[fuel_gauge_pkg::CFG_SOFT_SHUTDOWN];
  assign flag_clear = q.clear_interrupts;
  assign dir_reverse = (charge_current_detected && !discharge_current_detected &&
                        !q.current_direction_indicator) ||
                       (discharge_current_detected && !charge_current_detected &&
                        q.current_direction_indicator);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    next_q                  = q;
    next_q.clear_interrupts = 1'b0;

    // Serial link engine, slave only
    if (stop_seen) begin
      next_q.st        = fuel_gauge_pkg::LINK_IDLE;
      next_q.sda_drive = 1'b0;
    end else if (start_seen) begin
      next_q.st        = fuel_gauge_pkg::LINK_ADDR;
      next_q.bitcnt    = 4'h0;
      next_q.byte_idx  = 1'b0;
      next_q.sda_drive = 1'b0;
    end else begin
      if (rx_state && scl_rise && q.bitcnt != fuel_gauge_pkg::BITS_PER_BYTE) begin
        next_q.shreg  = {q.shreg[6:0], sda_level};
        next_q.bitcnt = 4'(q.bitcnt + 4'h1);
      end
      case (q.st)
        fuel_gauge_pkg::LINK_ADDR: begin
          if (rx_done) begin
            next_q.bitcnt = 4'h0;
            if (q.shreg[7:1] == fuel_gauge_pkg::SLAVE_ADDRESS) begin
              next_q.rw        = q.shreg[0];
              next_q.sda_drive = 1'b1;
              next_q.st        = fuel_gauge_pkg::LINK_ADDR_ACK;
            end else begin
              next_q.st = fuel_gauge_pkg::LINK_IGNORE;
            end
          end
        end
        fuel_gauge_pkg::LINK_ADDR_ACK: begin
          if (scl_fall) begin
            if (q.rw) begin
              // Reuses the latched command: Receive-Byte path
              next_q.shreg     = read_byte(q.cmd_latch, 1'b0, status_now);
              next_q.sda_drive = ~next_q.shreg[7];
              next_q.st        = fuel_gauge_pkg::LINK_TX;
            end else begin
              next_q.sda_drive = 1'b0;
              next_q.st        = fuel_gauge_pkg::LINK_CMD;
            end
          end
        end
        fuel_gauge_pkg::LINK_CMD: begin
          if (rx_done) begin
            next_q.bitcnt    = 4'h0;
            next_q.cmd_latch = q.shreg;
            next_q.sda_drive = 1'b1;
            next_q.st        = fuel_gauge_pkg::LINK_CMD_ACK;
          end
        end
        fuel_gauge_pkg::LINK_CMD_ACK: begin
          if (scl_fall) begin
            next_q.sda_drive = 1'b0;
            next_q.byte_idx  = 1'b0;
            next_q.st        = fuel_gauge_pkg::LINK_WDATA;
          end
        end
        fuel_gauge_pkg::LINK_WDATA: begin
          if (rx_done) begin
            next_q.bitcnt    = 4'h0;
            next_q.sda_drive = 1'b1;
            next_q.st        = fuel_gauge_pkg::LINK_WDATA_ACK;
            if (!q.byte_idx) begin
              next_q.wlow = q.shreg;
            end else if (q.cmd_latch == fuel_gauge_pkg::CONFIGURATION_WRITE_COMMAND) begin
              next_q.config_word = {q.shreg, q.wlow} & fuel_gauge_pkg::CFG_STORE_MASK;
              next_q.clear_interrupts = q.wlow[fuel_gauge_pkg::CFG_CLEAR_INTERRUPTS];
            end
          end
        end
        fuel_gauge_pkg::LINK_WDATA_ACK: begin
          if (scl_fall) begin
            next_q.sda_drive = 1'b0;
            next_q.byte_idx  = 1'b1;
            next_q.st        = q.byte_idx ? fuel_gauge_pkg::LINK_IGNORE
                                          : fuel_gauge_pkg::LINK_WDATA;
          end
        end
        fuel_gauge_pkg::LINK_TX: begin
          if (scl_rise) begin
            next_q.bitcnt = 4'(q.bitcnt + 4'h1);
          end else if (scl_fall) begin
            if (q.bitcnt == fuel_gauge_pkg::BITS_PER_BYTE) begin
              next_q.bitcnt    = 4'h0;
              next_q.sda_drive = 1'b0;
              next_q.st        = fuel_gauge_pkg::LINK_TX_ACK;
            end else begin
              next_q.shreg     = {q.shreg[6:0], 1'b1};
              next_q.sda_drive = ~q.shreg[6];
            end
          end
        end
        fuel_gauge_pkg::LINK_TX_ACK: begin
          if (scl_rise && sda_level) begin
            next_q.st = fuel_gauge_pkg::LINK_IGNORE;
          end else if (scl_fall) begin
            next_q.byte_idx  = ~q.byte_idx;
            next_q.shreg     = read_byte(q.cmd_latch, ~q.byte_idx, status_now);
            next_q.sda_drive = ~next_q.shreg[7];
            next_q.st        = fuel_gauge_pkg::LINK_TX;
          end
        end
        default: begin
          next_q.sda_drive = 1'b0;
        end
      endcase
    end

    // Status flags; reads never touch them
    if (shutdown) begin
      next_q.discharge_overcurrent_flag = 1'b0;
      next_q.charge_overcurrent_flag    = 1'b0;
      next_q.compare_match_flag         = 1'b0;
      next_q.direction_change_flag      = 1'b0;
    end else begin
      next_q.discharge_overcurrent_flag = discharge_overcurrent_event |
        (q.discharge_overcurrent_flag & ~flag_clear);
      next_q.charge_overcurrent_flag    = charge_overcurrent_event |
        (q.charge_overcurrent_flag & ~flag_clear);
      next_q.compare_match_flag         = compare_interrupt |
        (q.compare_match_flag & ~flag_clear);
      next_q.direction_change_flag      = dir_reverse |
        (q.direction_change_flag & ~flag_clear);
    end
    if (charge_current_detected && !discharge_current_detected) begin
      next_q.current_direction_indicator = 1'b1;
    end else if (discharge_current_detected && !charge_current_detected) begin
      next_q.current_direction_indicator = 1'b0;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q.st                          <= fuel_gauge_pkg::LINK_IDLE;
      q.shreg                       <= 8'h00;
      q.bitcnt                      <= 4'h0;
      q.rw                          <= 1'b0;
      q.byte_idx                    <= 1'b0;
      q.cmd_latch                   <= 8'h00;
      q.wlow                        <= 8'h00;
      q.config_word                 <= fuel_gauge_pkg::CFG_RESET;
      q.sda_drive                   <= 1'b0;
      q.clear_interrupts            <= 1'b0;
      q.discharge_overcurrent_flag  <= 1'b0;
      q.charge_overcurrent_flag     <= 1'b0;
      q.compare_match_flag          <= 1'b0;
      q.current_direction_indicator <= 1'b0;
      q.direction_change_flag       <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign sda_out              = 1'b0;
  assign sda_oe_n             = ~q.sda_drive;
  assign configuration_word   = q.config_word;
  assign soft_shutdown_enable = q.config_word[fuel_gauge_pkg::CFG_SOFT_SHUTDOWN];
  assign counter_select       = q.config_word[fuel_gauge_pkg::CFG_COUNTER_SELECT];
  assign clear_interrupts     = q.clear_interrupts;
  assign device_status_word   = status_now;

endmodule : fuel_gauge_status_word

/* File: test/fuel_gauge_status_word_sva.sv */
`timescale 1ns/100ps
module fuel_gauge_status_word_sva (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Bus pin
  input  wire logic        sda_out,
  // Measurement events
  input  wire logic        discharge_overcurrent_event,
  input  wire logic        charge_overcurrent_event,
  input  wire logic        compare_interrupt,
  input  wire logic        charge_current_detected,
  input  wire logic        discharge_current_detected,
  // Configuration and status
  input  wire logic [15:0] configuration_word,
  input  wire logic        soft_shutdown_enable,
  input  wire logic        counter_select,
  input  wire logic        clear_interrupts,
  input  wire logic [15:0] device_status_word
);
  logic [15:0] st;
  logic        chg;
  logic        dis;
  logic        quiet;
  assign st    = device_status_word;
  assign chg   = charge_current_detected && !discharge_current_detected;
  assign dis   = discharge_current_detected && !charge_current_detected;
  assign quiet = !(discharge_overcurrent_event || charge_overcurrent_event ||
                   compare_interrupt || charge_current_detected || discharge_current_detected);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // Status word
  // ==========================================================================
  a_unused_ones: assert property (st[15:8] == 8'hFF && st[0])
    else $error("unused status bits not one");
  a_dis_oc_set: assert property (discharge_overcurrent_event && !soft_shutdown_enable |=> st[7])
    else $error("discharge overcurrent flag not set");
  a_chg_oc_set: assert property (charge_overcurrent_event && !soft_shutdown_enable |=> st[6])
    else $error("charge overcurrent flag not set");
  a_cmp_set: assert property (compare_interrupt && !soft_shutdown_enable |=> st[5])
    else $error("compare flag not set");
  a_clear_flags: assert property (clear_interrupts && quiet |=> st[7:5] == 3'h0 && !st[1])
    else $error("flags survive clear");
  a_clear_single: assert property (clear_interrupts |=> !clear_interrupts)
    else $error("clear pulse too long");
  a_shdn_clears: assert property (soft_shutdown_enable |=> st[7:5] == 3'h0 && !st[1])
    else $error("flags set in shutdown");
  a_mirror_bits: assert property (st[4] == counter_select && st[3] == soft_shutdown_enable)
    else $error("mirror bits wrong");
  a_cfg_fields: assert property (soft_shutdown_enable == configuration_word[9] &&
    counter_select == configuration_word[6] && !configuration_word[7])
    else $error("configuration outputs wrong");
  a_dir_track: assert property (chg || dis |=> st[2] == $past(chg))
    else $error("direction bit wrong");
  a_dir_change: assert property ((chg && !st[2] || dis && st[2]) && !soft_shutdown_enable |=> st[1])
    else $error("direction change not flagged");
  a_flag_hold: assert property (st[7] && !clear_interrupts && !soft_shutdown_enable |=> st[7])
    else $error("flag lost without clear");
  a_sda_low: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
endmodule : fuel_gauge_status_word_sva

/* File: test/smbus_host_model.sv */
`timescale 1ns/100ps
module smbus_host_model (
  // Clock
  input  wire logic clk_sys,
  // Bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  logic nak_seen;
  initial begin
    scl      = 1'b1;
    sda_drv  = 1'b1;
    nak_seen = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #10;
  endtask : tick
  // Low phase 600 ns, sampled late in the high phase
  task automatic bit_x(input logic d, output logic r);
    scl = 1'b0;
    tick(3);
    sda_drv = d;
    tick(3);
    scl = 1'b1;
    tick(2);
    r = sda_line;
  endtask : bit_x
  // Start or repeated start when s is 1, stop otherwise
  task automatic frame(input logic s);
    scl = 1'b0;
    tick(3);
    sda_drv = s;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_drv = !s;
    tick(4);
  endtask : frame
  task automatic byte_x(input logic [7:0] d, input logic a, output logic [7:0] q,
                        output logic r);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(a, r);
  endtask : byte_x
  task automatic wbyte(input logic [7:0] d);
    logic [7:0] q;
    logic       r;
    byte_x(d, 1'b1, q, r);
    nak_seen = nak_seen | r;
  endtask : wbyte
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] w);
    logic r;
    frame(1'b1);
    wbyte({fuel_gauge_pkg::SLAVE_ADDRESS, 1'b0});
    wbyte(cmd);
    frame(1'b1);
    wbyte({fuel_gauge_pkg::SLAVE_ADDRESS, 1'b1});
    byte_x(8'hFF, 1'b0, w[7:0], r);
    byte_x(8'hFF, 1'b1, w[15:8], r);
    frame(1'b0);
  endtask : read_word
  task automatic recv_byte(output logic [7:0] b);
    logic r;
    frame(1'b1);
    wbyte({fuel_gauge_pkg::SLAVE_ADDRESS, 1'b1});
    byte_x(8'hFF, 1'b1, b, r);
    frame(1'b0);
  endtask : recv_byte
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] w);
    frame(1'b1);
    wbyte({fuel_gauge_pkg::SLAVE_ADDRESS, 1'b0});
    wbyte(cmd);
    wbyte(w[7:0]);
    wbyte(w[15:8]);
    frame(1'b0);
  endtask : write_word
endmodule : smbus_host_model

/* File: test/test_fuel_gauge_status_word.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module test_fuel_gauge_status_word;
  logic        clk_sys;
  logic        reset_n;
  logic        scl;
  logic        sda_drv;
  logic        sda_line;
  logic        sda_out;
  logic        sda_oe_n;
  logic        dis_oc;
  logic        chg_oc;
  logic        cmp_int;
  logic        chg_det;
  logic        dis_det;
  int          clr_cnt = 0;
  logic [15:0] configuration_word;
  logic        soft_shutdown_enable;
  logic        counter_select;
  logic        clear_interrupts;
  logic [15:0] device_status_word;
  logic [15:0] w;
  logic [7:0]  b;
  int          error_cnt = 0;
  int          checks = 0;
  int          cyc = 0;
  // Open-drain data line with pull-up
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  fuel_gauge_status_word fuel_gauge_status_word_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .discharge_overcurrent_event(dis_oc), .charge_overcurrent_event(chg_oc),
    .compare_interrupt(cmp_int), .charge_current_detected(chg_det),
    .discharge_current_detected(dis_det), .configuration_word(configuration_word),
    .soft_shutdown_enable(soft_shutdown_enable), .counter_select(counter_select),
    .clear_interrupts(clear_interrupts), .device_status_word(device_status_word)
  );
  smbus_host_model host_i (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Counts clear pulses away from the edge that launches them
  always @(negedge clk_sys) begin
    if (clear_interrupts === 1'b1) begin
      clr_cnt++;
    end
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  // One-cycle event pulse; mask bit 0 is discharge overcurrent, bit 4 discharge detect
  task automatic pulse(input logic [4:0] m);
    {dis_det, chg_det, cmp_int, chg_oc, dis_oc} = m;
    host_i.tick(1);
    {dis_det, chg_det, cmp_int, chg_oc, dis_oc} = 5'h00;
    host_i.tick(1);
  endtask : pulse
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    reset_n = 1'b0;
    {dis_det, chg_det, cmp_int, chg_oc, dis_oc} = 5'h00;
    repeat (3) @(posedge clk_sys);
    #10;
    reset_n = 1'b1;
    `CHK(device_status_word, 16'hFF01)
    `CHK(configuration_word, 16'h0000)
    host_i.tick(3);
    host_i.read_word(fuel_gauge_pkg::STATUS_READ_COMMAND, w);
    `CHK(w, 16'hFF01)
    for (int k = 0; k < 4; k++) begin
      pulse(5'h01 << k);
    end
    `CHK(device_status_word, 16'hFFE7)
    host_i.read_word(fuel_gauge_pkg::STATUS_READ_COMMAND, w);
    `CHK(w, 16'hFFE7)
    host_i.recv_byte(b);
    `CHK(b, 8'hE7)
    host_i.recv_byte(b);
    `CHK(b, 8'hE7)
    host_i.write_word(fuel_gauge_pkg::CONFIGURATION_WRITE_COMMAND, 16'h00C0);
    host_i.tick(2);
    `CHK(counter_select, 1'b1)
    `CHK(configuration_word, 16'h0040)
    `CHK(device_status_word, 16'hFF15)
    pulse(5'h10);
    `CHK(device_status_word, 16'hFF13)
    host_i.write_word(fuel_gauge_pkg::CONFIGURATION_WRITE_COMMAND, 16'h0240);
    host_i.tick(2);
    `CHK(soft_shutdown_enable, 1'b1)
    `CHK(device_status_word, 16'hFF19)
    pulse(5'h01);
    `CHK(device_status_word, 16'hFF19)
    host_i.write_word(fuel_gauge_pkg::CONFIGURATION_WRITE_COMMAND, 16'h0040);
    host_i.tick(2);
    `CHK(device_status_word, 16'hFF11)
    host_i.recv_byte(b);
    `CHK(b, 8'hFF)
    `CHK(clr_cnt, 1)
    `CHK(host_i.nak_seen, 1'b0)
    host_i.frame(1'b1);
    host_i.wbyte(8'h90);
    host_i.frame(1'b0);
    `CHK(host_i.nak_seen, 1'b1)
    finish_test();
  end
endmodule : test_fuel_gauge_status_word
bind fuel_gauge_status_word fuel_gauge_status_word_sva fuel_gauge_status_word_sva_i (
  .clk_sys, .reset_n, .sda_out, .discharge_overcurrent_event, .charge_overcurrent_event,
  .compare_interrupt, .charge_current_detected, .discharge_current_detected,
  .configuration_word, .soft_shutdown_enable, .counter_select, .clear_interrupts,
  .device_status_word
);
